// ---- pbd_bridge.v ----
// Processor bus decoder, instrument port adapter and power-up reset
// ****************************************************************
// How it works
// - Selects: system RAM 0000-07FF, select_a 0800-0FFF, port, gpib, option switches.
// - Primary decode needs valid address and A15,A14 zero; bits 13:11, top two unused.
// - Secondary decode enabled by 1000-17FF window, decodes bits 10:9.
// - Further primary codes light status lamps when accessed.
// - Adapter answers only at 1000-1003; other two selects always active.
// - Select code 00/10 picks port or direction by control bit 2; 01/11 control.
// - Direction bit 0 makes port line input, 1 makes it output.
// - Write low accepts bus data, read high drives adapter data out.
// - Write data captured during the phase-two high pulse.
// - Control bits 5:3 set behaviour of each side's second control line.
// - A-side second control line is the poll signal.
// - B-side second control line is data-valid, latches writes, enables reads.
// - Data-valid rises late, falls at once.
// - Service request goes straight to processor interrupt input.
// - Adapter reset at power-up, then programmed by processor.
// - Processor reset held low about one second after power-up, clocks run.
// - Data bus gate follows phase-two clock.
// - Port A eight lines drive instrument bus address.
// - Port B eight lines carry register data either way.
// - Data-valid pulses after a port B write only in pulse mode, control bits 5:3 = 5.
// ****************************************************************
`timescale 1ns/1ps
`include "pbd_defines.vh"
module pbd_bridge #(
    parameter PWR_HOLD_CYC = `PBD_PWR_HOLD_CYC
) (
    // Clock and reset
    input wire core_clk,
    input wire srst,
    // Microcomputer bus from processor
    input wire [15:0] cpu_addr,
    input wire valid_address_flag,
    input wire cpu_rd_wr,
    input wire phase2_clk,
    input wire [7:0] cpu_wdata,
    output reg [7:0] cpu_rdata_ff,
    output wire cpu_rdata_oe,
    output wire data_bus_gate,
    output wire tristate_control_in,
    output reg cpu_reset_n_ff,
    output wire cpu_irq_n,
    // Address selects
    output wire system_ram_select,
    output wire select_a,
    output wire port_select,
    output wire gpib_adapter_chip,
    output wire option_switch_select,
    output wire [2:0] lamp_select,
    // Instrument bus
    input wire [7:0] port_a_in,
    output reg [7:0] port_a_out_ff,
    output reg [7:0] port_a_oe_ff,
    input wire [7:0] port_b_in,
    output reg [7:0] port_b_out_ff,
    output reg [7:0] port_b_oe_ff,
    output wire a_side_control_line,
    output wire b_side_control_line,
    input wire service_request_line
);
    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    reg [15:0] addr_s1_ff, addr_ff;
    reg [7:0] wd_s1_ff, wd_ff, pa_s1_ff, pa_ff, pb_s1_ff, pb_ff;
    reg [3:0] ctl_s1_ff, ctl_ff;
    wire addr_valid = ctl_ff[0];
    wire rd_wr = ctl_ff[1];
    wire ph2 = ctl_ff[2];
    wire srq = ctl_ff[3];

    always @(posedge core_clk) begin
        if (srst) begin
            addr_s1_ff <= 16'h0000;
            addr_ff <= 16'h0000;
            wd_s1_ff <= 8'h00;
            wd_ff <= 8'h00;
            pa_s1_ff <= 8'h00;
            pa_ff <= 8'h00;
            pb_s1_ff <= 8'hff;
            pb_ff <= 8'hff;
            ctl_s1_ff <= 4'h2;
            ctl_ff <= 4'h2;
        end else begin
            addr_s1_ff <= cpu_addr;
            addr_ff <= addr_s1_ff;
            wd_s1_ff <= cpu_wdata;
            wd_ff <= wd_s1_ff;
            pa_s1_ff <= port_a_in;
            pa_ff <= pa_s1_ff;
            pb_s1_ff <= port_b_in;
            pb_ff <= pb_s1_ff;
            ctl_s1_ff <= {service_request_line, phase2_clk, cpu_rd_wr, valid_address_flag};
            ctl_ff <= ctl_s1_ff;
        end
    end

    // ****************************************************************
    // Address decode
    // ****************************************************************
    function [7:0] pbd_dec8;
        input en;
        input [2:0] code;
        begin
            pbd_dec8 = en ? (8'h01 << code) : 8'h00;
        end
    endfunction

    function [3:0] pbd_dec4;
        input en;
        input [1:0] code;
        begin
            pbd_dec4 = en ? (4'h1 << code) : 4'h0;
        end
    endfunction

    wire pri_en = addr_valid && (addr_ff[15:14] == 2'b00);
    wire [7:0] pri = pbd_dec8(pri_en, addr_ff[13:11]);
    wire [3:0] sec = pbd_dec4(pri[`PBD_PRI_IO], addr_ff[10:9]);

    assign system_ram_select = pri[`PBD_PRI_SYSTEM_RAM];
    assign select_a = pri[`PBD_PRI_SEL_A];
    assign port_select = sec[`PBD_SEC_PORT];
    assign gpib_adapter_chip = sec[`PBD_SEC_GPIB];
    assign option_switch_select = sec[`PBD_SEC_OPT_SW];
    // Diagnostics touch these pages to light a lamp
    assign lamp_select = {pri[`PBD_PRI_LAMP2], pri[`PBD_PRI_LAMP1],
                          pri[`PBD_PRI_LAMP0]};

    // ****************************************************************
    // Processor side fixed lines and reset
    // ****************************************************************
    assign data_bus_gate = phase2_clk;
    assign tristate_control_in = 1'b0;
    // Straight path, no adapter involvement
    assign cpu_irq_n = ~srq;

    reg [31:0] pwr_cnt_ff;
    always @(posedge core_clk) begin
        if (srst) begin
            pwr_cnt_ff <= 32'h00000000;
            cpu_reset_n_ff <= 1'b0;
        end else if (pwr_cnt_ff >= PWR_HOLD_CYC - 1) begin
            cpu_reset_n_ff <= 1'b1;
        end else begin
            pwr_cnt_ff <= pwr_cnt_ff + 32'h00000001;
        end
    end

    // ****************************************************************
    // Adapter registers
    // ****************************************************************
    reg [7:0] dir_a_ff, dir_b_ff, ctl_a_ff, ctl_b_ff;
    reg ph2_d_ff;
    reg dv_pulse_ff;
    // Two fixed selects are tied active; page select and address bits 8:2 zero decide
    wire adapter_chip_select = port_select &&
        ({addr_ff[15:2], 2'b00} == `PBD_ADAPTER_BASE);
    wire [1:0] rsel = {addr_ff[1], addr_ff[0]}; // reg_select_high, reg_select_low
    wire a_select_bit = ctl_a_ff[`PBD_CR_SEL_BIT];
    wire b_select_bit = ctl_b_ff[`PBD_CR_SEL_BIT];
    wire ph2_rise = ph2 && !ph2_d_ff;
    wire wr_stb = adapter_chip_select && !rd_wr && ph2_rise;
    wire rd_stb = adapter_chip_select && rd_wr && ph2_rise;
    wire [2:0] mode_a = ctl_a_ff[5:3];
    wire [2:0] mode_b = ctl_b_ff[5:3];

    always @(posedge core_clk) begin
        if (srst) begin
            // All lines inputs; A control line low, B data-valid asserts after its rise delay
            dir_a_ff <= `PBD_RST_REG;
            dir_b_ff <= `PBD_RST_REG;
            ctl_a_ff <= `PBD_RST_REG;
            ctl_b_ff <= `PBD_RST_REG;
            port_a_out_ff <= `PBD_RST_REG;
            port_b_out_ff <= `PBD_RST_REG;
            ph2_d_ff <= 1'b0;
            dv_pulse_ff <= 1'b0;
        end else begin
            ph2_d_ff <= ph2;
            // Pulse ends on the next phase-two rising edge
            if (ph2_rise) begin
                dv_pulse_ff <= 1'b0;
            end
            if (wr_stb) begin
                case (rsel)
                    `PBD_RS_A: begin
                        if (a_select_bit) begin
                            port_a_out_ff <= wd_ff;
                        end else begin
                            dir_a_ff <= wd_ff;
                        end
                    end
                    `PBD_RS_CTL_A: begin
                        ctl_a_ff <= wd_ff;
                    end
                    `PBD_RS_B: begin
                        if (b_select_bit) begin
                            port_b_out_ff <= wd_ff;
                            dv_pulse_ff <= (mode_b == `PBD_MODE_PULSE);
                        end else begin
                            dir_b_ff <= wd_ff;
                        end
                    end
                    default: begin
                        ctl_b_ff <= wd_ff;
                    end
                endcase
            end
        end
    end

    // Output enables follow direction registers
    always @(posedge core_clk) begin
        if (srst) begin
            port_a_oe_ff <= 8'h00;
            port_b_oe_ff <= 8'h00;
        end else begin
            port_a_oe_ff <= dir_a_ff;
            port_b_oe_ff <= dir_b_ff;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    function [7:0] pbd_port_rd;
        input [7:0] dir;
        input [7:0] out;
        input [7:0] pin;
        begin
            // Output lines read back the latch, inputs read the pin
            pbd_port_rd = (dir & out) | (~dir & pin);
        end
    endfunction

    reg [7:0] nxt_rdata;
    always @* begin
        case (rsel)
            `PBD_RS_A: nxt_rdata = a_select_bit ?
                pbd_port_rd(dir_a_ff, port_a_out_ff, pa_ff) : dir_a_ff;
            `PBD_RS_CTL_A: nxt_rdata = ctl_a_ff;
            `PBD_RS_B: nxt_rdata = b_select_bit ?
                pbd_port_rd(dir_b_ff, port_b_out_ff, pb_ff) : dir_b_ff;
            default: nxt_rdata = ctl_b_ff;
        endcase
    end

    always @(posedge core_clk) begin
        if (srst) begin
            cpu_rdata_ff <= 8'h00;
        end else if (rd_stb) begin
            cpu_rdata_ff <= nxt_rdata;
        end
    end

    // Drive the processor data bus only in phase two of an adapter read
    assign cpu_rdata_oe = adapter_chip_select && rd_wr && ph2;

    // ****************************************************************
    // Second control lines
    // ****************************************************************
    function pbd_ctl_line;
        input [2:0] mode;
        input pulse;
        begin
            case (mode)
                `PBD_MODE_HIGH: pbd_ctl_line = 1'b1;
                `PBD_MODE_PULSE: pbd_ctl_line = ~pulse;
                `PBD_MODE_HANDSHAKE: pbd_ctl_line = ~pulse;
                default: pbd_ctl_line = 1'b0;
            endcase
        end
    endfunction

    // Poll is asserted by programming the line high
    assign a_side_control_line = pbd_ctl_line(mode_a, 1'b0);

    // Low control line asserts data-valid through an inverter
    wire b_line_raw = pbd_ctl_line(mode_b, dv_pulse_ff);
    wire dv_req = ~b_line_raw;
    wire b_dv_ff;

    pbd_rise_delay #(
        .CYC(`PBD_DV_RISE_CYC)
    ) u_dv_delay (
        .core_clk(core_clk),
        .srst(srst),
        .lvl_in(dv_req),
        .lvl_out_ff(b_dv_ff)
    );

    assign b_side_control_line = b_dv_ff;
endmodule // pbd_bridge

// ---- pbd_bridge_monitor.sv ----
// Concurrent checks on the bridge top-level ports
`timescale 1ns/1ps
module pbd_bridge_monitor #(
    parameter PWR_HOLD_CYC = 50
) (
    // Clock and reset
    input wire core_clk,
    input wire srst,
    // Processor bus
    input wire [15:0] cpu_addr,
    input wire valid_address_flag,
    input wire phase2_clk,
    input wire data_bus_gate,
    input wire cpu_reset_n_ff,
    input wire cpu_irq_n,
    input wire cpu_rdata_oe,
    // Selects and instrument side
    input wire system_ram_select,
    input wire select_a,
    input wire port_select,
    input wire gpib_adapter_chip,
    input wire option_switch_select,
    input wire [2:0] lamp_select,
    input wire b_side_control_line,
    input wire service_request_line
);
    default clocking mon_cb @(posedge core_clk);
    endclocking
    default disable iff (srst);
    wire [7:0] sel = {system_ram_select, select_a, port_select, gpib_adapter_chip,
        option_switch_select, lamp_select};
    wire ram_page = valid_address_flag && cpu_addr[15:11] == 5'h00;
    wire io_page = valid_address_flag && cpu_addr[15:9] == 7'h08;
    int unsigned up_cnt;
    int unsigned low_cnt;
    // Saturating, so a long run never wraps into a false hold
    always @(posedge core_clk) begin
        if (srst) begin
            up_cnt <= 0;
            low_cnt <= 0;
        end else begin
            up_cnt <= (up_cnt < 1000) ? up_cnt + 1 : up_cnt;
            low_cnt <= b_side_control_line ? 0 : ((low_cnt < 1000) ? low_cnt + 1 : low_cnt);
        end
    end
    gate_follows_a: assert property (data_bus_gate == phase2_clk)
        else $error("data bus gate differs from phase two");
    irq_rise_a: assert property ($rose(service_request_line) |-> ##[1:4] !cpu_irq_n)
        else $error("interrupt not raised");
    irq_fall_a: assert property ($fell(service_request_line) |-> ##[1:4] cpu_irq_n)
        else $error("interrupt not dropped");
    sel_onehot_a: assert property ($onehot0(sel))
        else $error("several selects at once");
    ram_decode_a: assert property (ram_page [*4] |-> system_ram_select)
        else $error("system RAM select missing");
    port_decode_a: assert property (io_page [*4] |-> port_select)
        else $error("port select missing");
    idle_quiet_a: assert property ((!valid_address_flag) [*4] |-> sel == 8'h00)
        else $error("select without valid address");
    reset_hold_a: assert property (up_cnt + 2 < PWR_HOLD_CYC |-> !cpu_reset_n_ff)
        else $error("processor reset released early");
    reset_release_a: assert property (up_cnt > PWR_HOLD_CYC + 2 |-> cpu_reset_n_ff)
        else $error("processor reset held too long");
    dv_slow_rise_a: assert property ($rose(b_side_control_line) |-> low_cnt >= 16)
        else $error("data valid rose too soon");
    read_drive_a: assert property (cpu_rdata_oe |-> port_select)
        else $error("read drive outside adapter");
    cover property ($rose(b_side_control_line));
    cover property (cpu_rdata_oe);
    cover property ($fell(cpu_irq_n));
endmodule // pbd_bridge_monitor

// ---- pbd_cpu_model.sv ----
// Processor bus model: slow bus cycles on the fast core clock
`timescale 1ns/1ps
module pbd_cpu_model (
    // Clock
    input wire core_clk,
    // Microcomputer bus
    output logic [15:0] cpu_addr,
    output logic valid_address_flag,
    output logic cpu_rd_wr,
    output logic phase2_clk,
    output logic [7:0] cpu_wdata,
    input wire [7:0] cpu_rdata_ff
);
    // Processor state that the reset and interrupt sequences need
    logic irq_mask;
    logic [15:0] sp;
    initial begin
        cpu_addr = 16'hffff;
        irq_mask = 1'b1;
        sp = 16'h007f;
        valid_address_flag = 1'b0;
        cpu_rd_wr = 1'b1;
        phase2_clk = 1'b0;
        cpu_wdata = 8'h00;
    end
    // Each phase spans several edges so the input syncs see it
    task automatic cyc(input [15:0] a, input rw, input [7:0] d, input v, output [7:0] q);
        @(posedge core_clk) #1;
        cpu_addr = a;
        valid_address_flag = v;
        cpu_rd_wr = rw;
        cpu_wdata = rw ? ~cpu_wdata : d;
        repeat (4) @(posedge core_clk);
        #1 phase2_clk = 1'b1;
        repeat (6) @(posedge core_clk);
        q = cpu_rdata_ff;
        #1 phase2_clk = 1'b0;
        repeat (4) @(posedge core_clk);
        #1 cpu_addr = ~a;
        valid_address_flag = 1'b0;
        cpu_rd_wr = 1'b1;
        cpu_wdata = ~cpu_wdata;
    endtask
    task automatic place(input [15:0] a, input v);
        @(posedge core_clk) #1;
        cpu_addr = a;
        valid_address_flag = v;
        repeat (4) @(posedge core_clk);
    endtask
    // Reset vector fetch; interrupts stay masked until software clears the mask
    task automatic boot(output [15:0] vec);
        logic [7:0] q;
        irq_mask = 1'b1;
        cyc(16'hfffe, 1'b1, 8'h00, 1'b1, q);
        vec[15:8] = q;
        cyc(16'hffff, 1'b1, 8'h00, 1'b1, q);
        vec[7:0] = q;
    endtask
    // Interrupt entry: ignored while masked, else stack seven bytes and vector
    task automatic take_irq(input req_n, output taken, output [15:0] vec);
        logic [7:0] q;
        taken = 1'b0;
        vec = 16'h0000;
        if (!req_n && !irq_mask) begin
            for (int i = 0; i < 7; i++) begin
                cyc(sp, 1'b0, 8'h00, 1'b1, q);
                sp = sp - 16'h0001;
            end
            irq_mask = 1'b1;
            cyc(16'hfff8, 1'b1, 8'h00, 1'b1, q);
            vec[15:8] = q;
            cyc(16'hfff9, 1'b1, 8'h00, 1'b1, q);
            vec[7:0] = q;
            taken = 1'b1;
        end
    endtask
endmodule // pbd_cpu_model

// ---- pbd_defines.vh ----
// Constants for the processor bus decoder and instrument port bridge
`ifndef PBD_DEFINES_VH
`define PBD_DEFINES_VH
// Primary decode windows (address bits 13:11)
`define PBD_PRI_SYSTEM_RAM 3'h0
`define PBD_PRI_SEL_A 3'h1
`define PBD_PRI_IO 3'h2
`define PBD_PRI_LAMP0 3'h3
`define PBD_PRI_LAMP1 3'h4
`define PBD_PRI_LAMP2 3'h5
// Secondary decode codes (address bits 10:9)
`define PBD_SEC_PORT 2'h0
`define PBD_SEC_GPIB 2'h1
`define PBD_SEC_OPT_SW 2'h2
// Adapter base address, low two bits are register select
`define PBD_ADAPTER_BASE 16'h1000
// Register select codes
`define PBD_RS_A 2'h0
`define PBD_RS_CTL_A 2'h1
`define PBD_RS_B 2'h2
`define PBD_RS_CTL_B 2'h3
// Control register fields
`define PBD_CR_SEL_BIT 2
`define PBD_CR_MODE_LSB 3
// Control line modes (bits 5:3)
`define PBD_MODE_LOW 3'h6
`define PBD_MODE_HIGH 3'h7
`define PBD_MODE_PULSE 3'h5
`define PBD_MODE_HANDSHAKE 3'h4
// Reset values
`define PBD_RST_REG 8'h00
// Power-up reset hold, 1 s at 10 ns
`define PBD_PWR_HOLD_NS 1000000000
`define PBD_CLK_NS 10
`define PBD_PWR_HOLD_CYC (`PBD_PWR_HOLD_NS / `PBD_CLK_NS)
// Data-valid rise delay, 200 ns
`define PBD_DV_RISE_NS 200
`define PBD_DV_RISE_CYC (`PBD_DV_RISE_NS / `PBD_CLK_NS)
`endif

// ---- pbd_rise_delay.v ----
// Delays rising edges of a level, passes falling edges at once
`timescale 1ns/1ps
module pbd_rise_delay #(
    parameter CYC = 20
) (
    // Clock and reset
    input wire core_clk,
    input wire srst,
    // Level in and shaped level out
    input wire lvl_in,
    output reg lvl_out_ff
);
    reg [7:0] cnt_ff;

    always @(posedge core_clk) begin
        if (srst) begin
            cnt_ff <= 8'h00;
            lvl_out_ff <= 1'b0;
        end else if (!lvl_in) begin
            // Fall is immediate so the line releases without lag
            cnt_ff <= 8'h00;
            lvl_out_ff <= 1'b0;
        end else if (cnt_ff >= CYC[7:0] - 8'h01) begin
            lvl_out_ff <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end
endmodule // pbd_rise_delay

// ---- test_pbd_bridge.sv ----
// Self-checking bench for the processor bus bridge
`timescale 1ns/1ps
module test_pbd_bridge;
    localparam PWR_HOLD = 50;
    logic core_clk, srst, service_request_line;
    logic [7:0] port_a_in, port_b_in;
    wire [15:0] cpu_addr;
    wire valid_address_flag, cpu_rd_wr, phase2_clk, cpu_rdata_oe, data_bus_gate;
    wire tristate_control_in, cpu_reset_n_ff, cpu_irq_n, system_ram_select, select_a;
    wire port_select, gpib_adapter_chip, option_switch_select;
    wire a_side_control_line, b_side_control_line;
    wire [7:0] cpu_wdata, cpu_rdata_ff, port_a_out_ff, port_a_oe_ff, port_b_out_ff;
    wire [7:0] port_b_oe_ff, sels;
    wire [2:0] lamp_select;
    int n_fail = 0;
    int compares = 0;
    assign sels = {system_ram_select, select_a, port_select, gpib_adapter_chip,
        option_switch_select, lamp_select};
    pbd_bridge #(.PWR_HOLD_CYC(PWR_HOLD)) dut_u (.core_clk, .srst, .cpu_addr,
        .valid_address_flag, .cpu_rd_wr, .phase2_clk, .cpu_wdata, .cpu_rdata_ff,
        .cpu_rdata_oe, .data_bus_gate, .tristate_control_in, .cpu_reset_n_ff, .cpu_irq_n,
        .system_ram_select, .select_a, .port_select, .gpib_adapter_chip,
        .option_switch_select, .lamp_select, .port_a_in, .port_a_out_ff, .port_a_oe_ff,
        .port_b_in, .port_b_out_ff, .port_b_oe_ff, .a_side_control_line,
        .b_side_control_line, .service_request_line);
    pbd_cpu_model cpu_u (.core_clk, .cpu_addr, .valid_address_flag, .cpu_rd_wr,
        .phase2_clk, .cpu_wdata, .cpu_rdata_ff);
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic check(input [7:0] seen, input [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(input [15:0] a, input [7:0] d);
        logic [7:0] q;
        cpu_u.cyc(a, 1'b0, d, 1'b1, q);
    endtask
    task automatic rd(input [15:0] a, output [7:0] q);
        cpu_u.cyc(a, 1'b1, 8'h00, 1'b1, q);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        logic [7:0] q;
        logic [15:0] v;
        check(cpu_reset_n_ff, 1'b0);
        repeat (PWR_HOLD + 4) @(posedge core_clk);
        #1 check(cpu_reset_n_ff, 1'b1);
        check(port_b_oe_ff, 8'h00);
        check(tristate_control_in, 1'b0);
        cpu_u.boot(v);
        rd(16'h1003, q);
        check(q, 8'h00);
    endtask
    task automatic t_decode;
        logic [15:0] ad [15] = '{16'h0000, 16'h07ff, 16'h0800, 16'h1000, 16'h11ff,
            16'h1200, 16'h1400, 16'h1600, 16'h1800, 16'h2000, 16'h2800, 16'h3000,
            16'h3800, 16'h4000, 16'h8000};
        logic [7:0] ex [15] = '{8'h80, 8'h80, 8'h40, 8'h20, 8'h20, 8'h10, 8'h08, 8'h00,
            8'h01, 8'h02, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 15; i++) begin
            cpu_u.place(ad[i], 1'b1);
            #1 check(sels, ex[i]);
        end
        cpu_u.place(16'h1000, 1'b0);
        #1 check(sels, 8'h00);
    endtask
    task automatic t_ports;
        logic [7:0] q;
        wr(16'h1001, 8'h00);
        wr(16'h1000, 8'hff);
        rd(16'h1000, q);
        check(q, 8'hff);
        wr(16'h1001, 8'h04);
        wr(16'h1000, 8'h5a);
        check(port_a_out_ff, 8'h5a);
        check(port_a_oe_ff, 8'hff);
        wr(16'h1003, 8'h00);
        wr(16'h1002, 8'h0f);
        wr(16'h1003, 8'h04);
        wr(16'h1002, 8'ha5);
        check(port_b_out_ff, 8'ha5);
        check(port_b_oe_ff, 8'h0f);
        port_b_in = 8'h3c;
        rd(16'h1002, q);
        check(q, 8'h35);
        rd(16'h1001, q);
        check(q, 8'h04);
    endtask
    task automatic t_strobe;
        logic [7:0] q;
        logic [7:0] md [3] = '{8'h38, 8'h30, 8'h00};
        wr(16'h1003, 8'h2c);
        wr(16'h1002, 8'h81);
        check(b_side_control_line, 1'b0);
        repeat (16) @(posedge core_clk);
        #1 check(b_side_control_line, 1'b1);
        rd(16'h1003, q);
        check(q, 8'h2c);
        check(b_side_control_line, 1'b0);
        wr(16'h1003, 8'h34);
        repeat (16) @(posedge core_clk);
        #1 check(b_side_control_line, 1'b1);
        wr(16'h1003, 8'h3c);
        check(b_side_control_line, 1'b0);
        for (int i = 0; i < 3; i++) begin
            wr(16'h1001, md[i]);
            check(a_side_control_line, md[i] == 8'h38);
        end
    endtask
    task automatic t_misc;
        logic [7:0] q;
        logic tk;
        logic [15:0] v;
        service_request_line = 1'b1;
        repeat (4) @(posedge core_clk);
        #1 check(cpu_irq_n, 1'b0);
        cpu_u.take_irq(cpu_irq_n, tk, v);
        check(tk, 1'b0);
        cpu_u.irq_mask = 1'b0;
        cpu_u.take_irq(cpu_irq_n, tk, v);
        check(tk, 1'b1);
        check(cpu_u.sp[7:0], 8'h78);
        check(cpu_u.irq_mask, 1'b1);
        service_request_line = 1'b0;
        repeat (4) @(posedge core_clk);
        #1 check(cpu_irq_n, 1'b1);
        wr(16'h1005, 8'hff);
        cpu_u.cyc(16'h1001, 1'b0, 8'hff, 1'b0, q);
        rd(16'h1001, q);
        check(q, 8'h00);
    endtask
    initial begin
        srst = 1'b1;
        service_request_line = 1'b0;
        port_a_in = 8'h00;
        port_b_in = 8'h00;
        repeat (2) @(posedge core_clk);
        #1 srst = 1'b0;
        t_reset();
        t_decode();
        t_ports();
        t_strobe();
        t_misc();
        final_report();
    end
    // Run needs about 690 cycles; generous margin
    initial begin
        repeat (6000) @(posedge core_clk);
        n_fail++;
        final_report();
    end
endmodule // test_pbd_bridge
bind pbd_bridge pbd_bridge_monitor #(.PWR_HOLD_CYC(PWR_HOLD_CYC)) mon_u (.core_clk, .srst,
    .cpu_addr, .valid_address_flag, .phase2_clk, .data_bus_gate, .cpu_reset_n_ff,
    .cpu_irq_n, .cpu_rdata_oe, .system_ram_select, .select_a, .port_select,
    .gpib_adapter_chip, .option_switch_select, .lamp_select, .b_side_control_line,
    .service_request_line);
